/* File: hdl/trim_device.sv */
/*
 * Trim device end: 11-bit shift register on the link clock, a modelled
 * nonvolatile word, bank selection and single-bit read-back.
 * Assumes the programmer keeps data low while pulsing and holds the
 * link clock high during evaluation, pulses and read-back.
 */
`timescale 1ns/1ps
`include "trim_defines.svh"

module trim_device (
    input  wire logic                     clock,
    input  wire logic                     resetn,
    trim_link_if.device                   link,
    output logic [`TRIM_MID_W-1:0]        mid_bank,
    output logic [`TRIM_FINE_W-1:0]       fine_bank_field,
    output logic [`TRIM_WORD_W-1:0]       stored_word
);
    localparam logic [`TRIM_WORD_W-1:0] ERASED = `TRIM_ERASED;

    logic [`TRIM_WORD_W-1:0] shift_q;
    logic [`TRIM_WORD_W-1:0] next_shift_q;
    logic [`TRIM_WORD_W-1:0] word;
    logic [`TRIM_WORD_W-1:0] next_word;
    logic [`TRIM_WORD_W-1:0] nv;
    logic [`TRIM_WORD_W-1:0] next_nv;
    logic [`TRIM_WORD_W-1:0] pick;
    logic [`TRIM_WORD_W-1:0] next_pick;
    logic [2:0]              clk_s;
    logic [1:0]              data_s;
    logic [2:0]              pulse_s;
    logic                    prog_edge;
    logic                    erase;
    logic                    next_dev;
    logic                    next_dev_oe;

    // R1 R18 - shift on rising edge only
    always_comb begin
        next_shift_q = {link.serial_data_in,
                        shift_q[`TRIM_LAST_BIT:1]};
    end

    always_ff @(posedge link.link_clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= '0;
        end else begin
            shift_q <= next_shift_q;
        end
    end

    // Own read-back needs data high, a burn pulse has data low
    assign prog_edge = pulse_s[1] & ~pulse_s[2] & clk_s[1] & ~data_s[1];
    // R15 - all-ones word erases the store
    assign erase = (word == `TRIM_ALL_ONES);

    // R4 - capture only once clock has stayed high
    always_comb begin
        next_word = (clk_s[1] & clk_s[2]) ? shift_q : word;
    end

    generate
        for (genvar i = 0; i < `TRIM_WORD_W; i++) begin : g_bit
            // R11 - only a low-selected bit is written
            always_comb begin
                next_nv[i] = nv[i];
                if (prog_edge) begin
                    if (erase) begin
                        next_nv[i] = ERASED[i];
                    end else if (!word[i]) begin
                        next_nv[i] = 1'b0;
                    end
                end
            end
            // R14 - low data bit picks the read bit
            if (i == 0) begin : g_low
                assign next_pick[i] = ~word[i];
            end else begin : g_up
                assign next_pick[i] = ~word[i] & (&word[i-1:0]);
            end
        end
    endgenerate

    // R14 - present picked bit while data and clock high
    always_comb begin
        next_dev    = |(pick & nv);
        next_dev_oe = clk_s[1] & data_s[1] & (|pick);
    end

    // R8 - synchronised pins read low when left open
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clk_s             <= '0;
            data_s            <= '0;
            pulse_s           <= '0;
            word              <= '0;
            nv                <= `TRIM_ERASED;
            pick              <= '0;
            mid_bank          <= '0;
            fine_bank_field   <= '0;
            stored_word       <= `TRIM_ERASED;
            link.pulse_dev    <= 1'b0;
            link.pulse_dev_oe <= 1'b0;
        end else begin
            clk_s             <= {clk_s[1:0], link.link_clk};
            data_s            <= {data_s[0], link.serial_data_in};
            pulse_s           <= {pulse_s[1:0], link.program_pulse_pin};
            word              <= next_word;
            nv                <= next_nv;
            pick              <= next_pick;
            stored_word       <= nv;
            link.pulse_dev    <= next_dev;
            link.pulse_dev_oe <= next_dev_oe;
            // R2 R5 R6 R7 - live bits high-active, stored low-active
            if (clk_s[2]) begin
                mid_bank        <= word[`TRIM_MID_LSB +: `TRIM_MID_W];
                fine_bank_field <= word[`TRIM_FINE_LSB +: `TRIM_FINE_W];
            end else begin
                mid_bank        <= ~nv[`TRIM_MID_LSB +: `TRIM_MID_W];
                fine_bank_field <= ~nv[`TRIM_FINE_LSB +: `TRIM_FINE_W];
            end
        end
    end
endmodule

/* File: hdl/trim_programmer.sv */
/*
 * Production programmer end: erases, reads, writes one bit per pulse
 * and verifies the trim word, or holds a trial word live.
 * Assumes the device end samples on the link clock made here.
 */
// Behaviour
// R1 - 11 bits shifted, bit 0 first
// R2 - bits 8..6 mid, 5..1 fine
// R3 - bits 0, 9, 10 still shifted
// R4 - live word used while clock high
// R5 - live bit one switches element in
// R6 - clock low or open selects store
// R7 - stored bit zero switches element in
// R8 - open pins pulled low
// R9 - erase first unless known erased
// R10 - read back, write only differing bits
// R11 - one bit per write, selected low
// R12 - load, one pulse, idle, per bit
// R13 - verify each bit by read-back
// R14 - read bit shown on pulse pin
// R15 - all-ones pulse erases, check bit high
// R16 - shift clock at most 100 kHz
// R17 - allow programming time per pulse
// R18 - shift register holds between edges
`timescale 1ns/1ps
`include "trim_defines.svh"

module trim_programmer #(
    parameter int PROG_CYC   = `TRIM_PROG_CYC,
    parameter int PULSE_CYC  = `TRIM_PULSE_CYC,
    parameter int HALF_CYC   = `TRIM_LINK_HALF,
    parameter int SETTLE_CYC = `TRIM_SETTLE_CYC,
    parameter int CNT_W      = 20
) (
    input  wire logic                    clock,
    input  wire logic                    resetn,
    trim_link_if.programmer              link,
    input  wire logic                    start,
    input  wire logic                    trial,
    input  wire logic                    known_erased,
    input  wire logic [`TRIM_WORD_W-1:0] target,
    output logic                         busy,
    output logic                         done,
    output logic                         fail,
    output logic [`TRIM_WORD_W-1:0]      readback
);
    localparam logic [3:0] LAST = 4'(`TRIM_LAST_BIT);

    trim_pkg::prog_state_e   state;
    trim_pkg::prog_state_e   next_state;
    trim_pkg::prog_phase_e   phase;
    trim_pkg::prog_phase_e   next_phase;
    logic [3:0]              idx;
    logic [3:0]              next_idx;
    logic [3:0]              bitcnt;
    logic [3:0]              next_bitcnt;
    logic [CNT_W-1:0]        cnt;
    logic [CNT_W-1:0]        next_cnt;
    logic [`TRIM_WORD_W-1:0] goal;
    logic [`TRIM_WORD_W-1:0] next_goal;
    logic [`TRIM_WORD_W-1:0] next_readback;
    logic [`TRIM_WORD_W-1:0] need;
    logic [`TRIM_WORD_W-1:0] cur_word;
    logic                    next_sclk;
    logic                    next_data;
    logic                    next_pulse;
    logic                    next_busy;
    logic                    next_done;
    logic                    next_fail;
    logic [1:0]              pin_s;

    // Word shifted for a phase; store selection is active low
    function automatic logic [`TRIM_WORD_W-1:0] word_for(
        input trim_pkg::prog_phase_e ph,
        input logic [3:0]            i,
        input logic [`TRIM_WORD_W-1:0] g
    );
        logic [`TRIM_WORD_W-1:0] w;
        w = `TRIM_ALL_ONES;
        if (ph == trim_pkg::P_TRIAL) begin
            w = g;
        end else if (ph != trim_pkg::P_ERASE) begin
            // R11 - single bit selected by a zero
            w[i] = 1'b0;
        end
        return w;
    endfunction

    // R10 - write only bits whose stored value differs
    assign need = readback & goal & `TRIM_LIVE_MASK;
    assign cur_word = word_for(phase, idx, goal);

    always_comb begin
        next_state    = state;
        next_phase    = phase;
        next_idx      = idx;
        next_bitcnt   = bitcnt;
        next_cnt      = cnt + 1'b1;
        next_goal     = goal;
        next_readback = readback;
        next_sclk     = link.sclk_drv;
        next_data     = link.data_drv;
        next_pulse    = link.pulse_prog;
        next_busy     = busy;
        next_done     = 1'b0;
        next_fail     = fail;
        unique case (state)
            trim_pkg::S_IDLE: begin
                next_cnt = '0;
                if (start) begin
                    next_goal = target;
                    next_busy = 1'b1;
                    next_fail = 1'b0;
                    next_idx  = '0;
                    next_state = trim_pkg::S_LOAD;
                    next_bitcnt = '0;
                    next_sclk   = 1'b0;
                    // R9 - erase unless already erased
                    if (trial) begin
                        next_phase = trim_pkg::P_TRIAL;
                    end else if (known_erased) begin
                        next_phase = trim_pkg::P_READ;
                    end else begin
                        next_phase = trim_pkg::P_ERASE;
                    end
                    // First bit: trial word, erase ones, or read zero
                    next_data = trial ? target[0] : ~known_erased;
                end
            end
            trim_pkg::S_LOAD: begin
                // R16 - half period sets shift clock rate
                if (cnt == CNT_W'(HALF_CYC - 1)) begin
                    next_sclk = 1'b1;
                end
                if (cnt == CNT_W'(2 * HALF_CYC - 1)) begin
                    next_cnt = '0;
                    // R1 R3 - all eleven bits go out
                    if (bitcnt == LAST) begin
                        next_state = trim_pkg::S_SETTLE;
                        next_data  = (phase == trim_pkg::P_READ) ||
                                     (phase == trim_pkg::P_VERIFY);
                    end else begin
                        next_bitcnt = bitcnt + 1'b1;
                        next_sclk   = 1'b0;
                        next_data   = cur_word[bitcnt + 1'b1];
                    end
                end
            end
            trim_pkg::S_SETTLE: begin
                if (cnt == CNT_W'(SETTLE_CYC - 1)) begin
                    next_cnt = '0;
                    unique case (phase)
                        trim_pkg::P_READ, trim_pkg::P_VERIFY: begin
                            // R13 R14 - sample one stored bit
                            next_readback[idx] = pin_s[1];
                            next_state = trim_pkg::S_SCAN;
                            next_idx   = idx + 1'b1;
                            next_sclk  = 1'b0;
                        end
                        trim_pkg::P_TRIAL: begin
                            next_state = trim_pkg::S_HOLD;
                        end
                        default: begin
                            // R12 - one pulse per loaded word
                            next_state = trim_pkg::S_PULSE;
                            next_pulse = 1'b1;
                        end
                    endcase
                end
            end
            trim_pkg::S_PULSE: begin
                if (cnt == CNT_W'(PULSE_CYC - 1)) begin
                    next_cnt   = '0;
                    next_pulse = 1'b0;
                    next_state = trim_pkg::S_REST;
                end
            end
            trim_pkg::S_REST: begin
                // R17 - idle for the programming time
                if (cnt == CNT_W'(PROG_CYC - 1)) begin
                    next_cnt   = '0;
                    next_sclk  = 1'b0;
                    next_state = trim_pkg::S_SCAN;
                    if (phase == trim_pkg::P_ERASE) begin
                        next_phase = trim_pkg::P_READ;
                        next_idx   = '0;
                    end else begin
                        next_idx   = idx + 1'b1;
                    end
                end
            end
            trim_pkg::S_SCAN: begin
                next_cnt    = '0;
                next_bitcnt = '0;
                if (idx > LAST) begin
                    next_idx = '0;
                    if (phase == trim_pkg::P_READ) begin
                        next_phase = trim_pkg::P_WRITE;
                    end else if (phase == trim_pkg::P_WRITE) begin
                        next_phase = trim_pkg::P_VERIFY;
                        next_data  = 1'b0;
                        next_state = trim_pkg::S_LOAD;
                    end else begin
                        next_state = trim_pkg::S_IDLE;
                        next_busy  = 1'b0;
                        next_done  = 1'b1;
                        next_fail  = ((readback ^ ~goal) &
                                      `TRIM_LIVE_MASK) != '0;
                    end
                end else if (phase != trim_pkg::P_WRITE || need[idx]) begin
                    next_state = trim_pkg::S_LOAD;
                    next_data  = cur_word[0];
                end else begin
                    next_idx = idx + 1'b1;
                end
            end
            trim_pkg::S_HOLD: begin
                // R4 - clock stays high to show the live word
                next_cnt = '0;
                if (!trial) begin
                    next_sclk  = 1'b0;
                    next_state = trim_pkg::S_IDLE;
                    next_busy  = 1'b0;
                    next_done  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state              <= trim_pkg::S_IDLE;
            phase              <= trim_pkg::P_READ;
            idx                <= '0;
            bitcnt             <= '0;
            cnt                <= '0;
            goal               <= '0;
            readback           <= '0;
            busy               <= 1'b0;
            done               <= 1'b0;
            fail               <= 1'b0;
            pin_s              <= '0;
            link.sclk_drv      <= 1'b0;
            link.data_drv      <= 1'b0;
            link.attach        <= 1'b0;
            link.pulse_prog    <= 1'b0;
            link.pulse_prog_oe <= 1'b0;
        end else begin
            state              <= next_state;
            phase              <= next_phase;
            idx                <= next_idx;
            bitcnt             <= next_bitcnt;
            cnt                <= next_cnt;
            goal               <= next_goal;
            readback           <= next_readback;
            busy               <= next_busy;
            done               <= next_done;
            fail               <= next_fail;
            pin_s              <= {pin_s[0], link.program_pulse_pin};
            link.sclk_drv      <= next_sclk;
            link.data_drv      <= next_data;
            // R6 R8 - detach when idle so the store rules
            link.attach        <= next_busy;
            link.pulse_prog    <= next_pulse;
            link.pulse_prog_oe <= next_pulse;
        end
    end
endmodule

/* File: pkg/trim_defines.svh */
/*
 * Constants of the trim word link: word layout, erased store value and
 * timing counts. Assumes a 40 MHz system clock on the programmer side.
 */
`ifndef TRIM_DEFINES_SVH
`define TRIM_DEFINES_SVH

`define TRIM_WORD_W      11
`define TRIM_LAST_BIT    10
`define TRIM_MID_LSB     6
`define TRIM_MID_W       3
`define TRIM_FINE_LSB    1
`define TRIM_FINE_W      5
`define TRIM_LIVE_MASK   11'h1fe
`define TRIM_ERASED      11'h7ff
`define TRIM_ALL_ONES    11'h7ff

`define TRIM_CLOCK_HZ    40000000
`define TRIM_LINK_MAX_HZ 100000
`define TRIM_LINK_HALF   ((`TRIM_CLOCK_HZ + 2 * `TRIM_LINK_MAX_HZ - 1) / (2 * `TRIM_LINK_MAX_HZ))
`define TRIM_PROG_US     10000
`define TRIM_PROG_CYC    (`TRIM_PROG_US * (`TRIM_CLOCK_HZ / 1000000))
`define TRIM_PULSE_US    1000
`define TRIM_PULSE_CYC   (`TRIM_PULSE_US * (`TRIM_CLOCK_HZ / 1000000))
`define TRIM_SETTLE_CYC  32

`endif

/* File: pkg/trim_link_if.sv */
/*
 * Three-pin programming link between programmer and trim device.
 * Assumes undriven pins are pulled low, as the device's pull-downs do.
 */
`timescale 1ns/1ps

interface trim_link_if;
    logic sclk_drv;
    logic data_drv;
    logic attach;
    logic pulse_prog;
    logic pulse_prog_oe;
    logic pulse_dev;
    logic pulse_dev_oe;
    logic link_clk;
    logic serial_data_in;
    logic program_pulse_pin;

    // Pull-downs win whenever the programmer is detached
    assign link_clk          = attach & sclk_drv;
    assign serial_data_in    = attach & data_drv;
    assign program_pulse_pin = pulse_prog_oe ? pulse_prog :
                               (pulse_dev_oe ? pulse_dev : 1'b0);

    modport programmer (
        output sclk_drv,
        output data_drv,
        output attach,
        output pulse_prog,
        output pulse_prog_oe,
        input  program_pulse_pin
    );

    modport device (
        input  link_clk,
        input  serial_data_in,
        input  program_pulse_pin,
        output pulse_dev,
        output pulse_dev_oe
    );
endinterface

/* File: pkg/trim_pkg.sv */
/*
 * Types shared by the trim word programmer.
 * Assumes nothing beyond the defines header.
 */
package trim_pkg;

    typedef enum logic [6:0] {
        S_IDLE   = 7'h01,
        S_LOAD   = 7'h02,
        S_SETTLE = 7'h04,
        S_PULSE  = 7'h08,
        S_REST   = 7'h10,
        S_SCAN   = 7'h20,
        S_HOLD   = 7'h40
    } prog_state_e;

    typedef enum logic [4:0] {
        P_ERASE  = 5'h01,
        P_READ   = 5'h02,
        P_WRITE  = 5'h04,
        P_VERIFY = 5'h08,
        P_TRIAL  = 5'h10
    } prog_phase_e;

endpackage

/* File: tb/test_trim_word_serial_programmer.sv */
/*
 * Testbench joining programmer and trim device over the link: live trial
 * words, burns with and without erase, store and bank checks.
 * Assumes a 40 MHz clock and shortened programmer counts.
 */
`timescale 1ns/1ps
`include "trim_defines.svh"

module test_trim_word_serial_programmer;
    logic                    clock;
    logic                    resetn;
    logic                    start;
    logic                    trial;
    logic                    known_erased;
    logic [`TRIM_WORD_W-1:0] target;
    logic                    busy;
    logic                    done;
    logic                    fail;
    logic [`TRIM_WORD_W-1:0] readback;
    logic [`TRIM_MID_W-1:0]  mid_bank;
    logic [`TRIM_FINE_W-1:0] fine_bank_field;
    logic [`TRIM_WORD_W-1:0] stored_word;
    logic [`TRIM_WORD_W-1:0] exp_store;
    int                      bad_count;
    int                      tests_run;
    int                      cycles = 0;

    localparam int HALF     = 8;
    localparam int LOAD_CYC = 22 * HALF + 24;

    trim_link_if trim_link_if_inst ();

    trim_programmer #(
        .PROG_CYC   (50),
        .PULSE_CYC  (20),
        .HALF_CYC   (HALF),
        .SETTLE_CYC (8)
    ) trim_programmer_inst (
        .clock        (clock),
        .resetn       (resetn),
        .link         (trim_link_if_inst),
        .start        (start),
        .trial        (trial),
        .known_erased (known_erased),
        .target       (target),
        .busy         (busy),
        .done         (done),
        .fail         (fail),
        .readback     (readback)
    );

    trim_device trim_device_inst (
        .clock           (clock),
        .resetn          (resetn),
        .link            (trim_link_if_inst),
        .mid_bank        (mid_bank),
        .fine_bank_field (fine_bank_field),
        .stored_word     (stored_word)
    );

    trim_link_properties trim_link_properties_inst (
        .clock          (clock),
        .resetn         (resetn),
        .attach         (trim_link_if_inst.attach),
        .sclk_drv       (trim_link_if_inst.sclk_drv),
        .pulse_prog_oe  (trim_link_if_inst.pulse_prog_oe),
        .pulse_dev_oe   (trim_link_if_inst.pulse_dev_oe),
        .link_clk       (trim_link_if_inst.link_clk),
        .serial_data_in (trim_link_if_inst.serial_data_in)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic give_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [10:0] exp,
                         input logic [10:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Banks placed at their word positions
    function automatic logic [10:0] banks();
        return {2'h0, mid_bank, fine_bank_field, 1'b0};
    endfunction

    task automatic await_banks(input logic [10:0] exp);
        for (int i = 0; i < 300 && banks() !== exp; i++) begin
            @(negedge clock);
        end
    endtask

    task automatic command(input logic [10:0] t, input logic tr,
                           input logic ke);
        @(posedge clock);
        start        <= 1'b1;
        target       <= t;
        trial        <= tr;
        known_erased <= ke;
        @(posedge clock);
        start <= 1'b0;
    endtask

    task automatic live(input logic [10:0] w);
        logic [10:0] exp;
        exp = w & `TRIM_LIVE_MASK;
        command(w, 1'b1, 1'b0);
        // Partial words show while shifting: wait out the whole load
        repeat (LOAD_CYC) @(negedge clock);
        check("live banks", exp, banks());
        repeat (40) @(negedge clock);
        check("live hold", exp, banks());
        check("live store", exp_store, stored_word);
        @(posedge clock);
        trial <= 1'b0;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
            @(negedge clock);
        end
        exp = ~exp_store & `TRIM_LIVE_MASK;
        await_banks(exp);
        check("idle banks", exp, banks());
    endtask

    task automatic burn(input logic [10:0] t, input logic ke);
        logic f;
        logic [10:0] exp;
        command(t, 1'b0, ke);
        // A start while busy must be dropped
        @(posedge clock);
        start  <= 1'b1;
        target <= 11'h000;
        @(posedge clock);
        start <= 1'b0;
        if (!ke) begin
            exp_store = `TRIM_ERASED;
        end
        exp_store = exp_store & ~(t & `TRIM_LIVE_MASK);
        f = |((exp_store ^ ~t) & `TRIM_LIVE_MASK);
        for (int i = 0; i < 20000 && done !== 1'b1; i++) begin
            @(negedge clock);
        end
        check("done", 11'h001, {10'h0, done});
        check("fail", {10'h0, f}, {10'h0, fail});
        check("readback", exp_store, readback);
        check("store", exp_store, stored_word);
        exp = ~exp_store & `TRIM_LIVE_MASK;
        await_banks(exp);
        check("stored banks", exp, banks());
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        resetn       = 1'b0;
        start        = 1'b0;
        trial        = 1'b0;
        known_erased = 1'b0;
        target       = 11'h000;
        bad_count    = 0;
        tests_run    = 0;
        exp_store    = `TRIM_ERASED;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        check("reset store", `TRIM_ERASED, stored_word);
        await_banks(11'h000);
        check("reset banks", 11'h000, banks());
        live(11'h664);
        live(11'h601);
        live(11'h1fe);
        burn(11'h014, 1'b1);
        burn(11'h7a2, 1'b0);
        burn(11'h014, 1'b1);
        live(11'h0aa);
        give_verdict();
    end
endmodule

/* File: tb/trim_link_properties.sv */
/*
 * Checker for the three-pin trim link: shift clock shape, data setup,
 * programming pulse framing, read-back drive and pulled-down open pins.
 * Assumes the programmer runs with HALF_CYC 8, PULSE_CYC 20, PROG_CYC 50
 * and is instantiated beside the link interface by the testbench.
 */
`timescale 1ns/1ps

module trim_link_properties (
    input wire logic clock,
    input wire logic resetn,
    input wire logic attach,
    input wire logic sclk_drv,
    input wire logic pulse_prog_oe,
    input wire logic pulse_dev_oe,
    input wire logic link_clk,
    input wire logic serial_data_in
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_open_pins_low: assert property (
        !attach |-> !link_clk && !serial_data_in)
        else $error("open link pins not low");

    a_shift_data_setup: assert property (
        $rose(link_clk) |-> $stable(serial_data_in))
        else $error("data moved at shift edge");

    a_clock_high_hold: assert property (
        $rose(sclk_drv) |=> sclk_drv [*3])
        else $error("shift clock high phase too short");

    a_clock_low_hold: assert property (
        $fell(sclk_drv) |=> !sclk_drv [*3])
        else $error("shift clock low phase too short");

    a_pulse_clock_high: assert property (
        pulse_prog_oe |-> link_clk && !serial_data_in)
        else $error("pulse without clock high and data low");

    a_pulse_one_width: assert property (
        $rose(pulse_prog_oe) |-> pulse_prog_oe [*8]
            ##[10:14] !pulse_prog_oe)
        else $error("programming pulse width wrong");

    a_prog_rest_time: assert property (
        $fell(pulse_prog_oe) |-> (link_clk && !pulse_prog_oe) [*8]
            ##[38:46] !link_clk)
        else $error("programming rest wrong");

    a_no_pin_fight: assert property (
        !(pulse_prog_oe && pulse_dev_oe))
        else $error("both ends drive pulse pin");

    a_readback_onset: assert property (
        $rose(pulse_dev_oe) |-> link_clk && serial_data_in)
        else $error("read-back drive without clock and data high");

    a_detached_quiet: assert property (
        !attach |-> !pulse_prog_oe)
        else $error("pulse while detached");

    cover property ($rose(pulse_prog_oe));
    cover property ($rose(pulse_dev_oe));
    cover property ($fell(attach));
endmodule
